// ---- uartrb_pkg.sv ----
// Constants, field layouts and carrier types of the serial receiver and break generator.
package uartrb_pkg;
	// ****************************************
	// Register addresses.
	// ****************************************
	localparam logic [2:0] ADDR_STATUS = 3'h0;
	localparam logic [2:0] ADDR_DATA = 3'h1;
	localparam logic [2:0] ADDR_CTRL1 = 3'h2;
	localparam logic [2:0] ADDR_CTRL2 = 3'h3;
	localparam logic [2:0] ADDR_BAUD = 3'h4;
	// ****************************************
	// Field positions.
	// ****************************************
	localparam int ST_RXDATA = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_NOISE = 2;
	localparam int ST_FRAMING = 3;
	localparam int ST_PARITY = 4;
	localparam int ST_RXIDLE = 5;
	localparam int ST_TXIDLE = 6;
	localparam int C1_NINE = 0;
	localparam int C1_PAREN = 1;
	localparam int C1_PARODD = 2;
	localparam int C1_TWOSTOP = 3;
	localparam int C1_BREAK = 4;
	localparam int C1_NINTH = 5;
	localparam int C1_RECEIVER_ENABLE = 6;
	localparam int C2_RIE = 0;
	// ****************************************
	// Reset values.
	// ****************************************
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [7:0] CTRL2_RST = 8'h00;
	localparam logic [7:0] BAUD_RST = 8'h19;
	// ****************************************
	// Timing counts.
	// ****************************************
	localparam logic [3:0] OVS_LAST = 4'hF;
	localparam logic [3:0] SMP_FIRST = 4'h7;
	localparam logic [3:0] SMP_MID = 4'h8;
	localparam logic [3:0] SMP_LAST = 4'h9;
	localparam logic [3:0] BRK_LAST = 4'hC;
	localparam logic [3:0] BITS_NINE = 4'h8;
	localparam logic [3:0] BITS_EIGHT = 4'h7;
	localparam logic [1:0] FIFO_DEPTH = 2'h2;
	// ****************************************
	// Carrier types.
	// ****************************************
	// One received word with the flags recorded beside it.
	typedef struct packed {
		logic ninth;
		logic [7:0] data;
		logic framing;
		logic parity;
	} uartrb_entry_s;
	// Frame format and control bits written by software.
	typedef struct packed {
		logic nineBit;
		logic parityEn;
		logic parityOdd;
		logic twoStop;
		logic sendBreak;
		logic rxEnable;
		logic rxIrqEn;
	} uartrb_cfg_s;
endpackage : uartrb_pkg

// ---- uartrb_top.sv ----
// Serial receive path with two-entry FIFO and transmit-break generator.
//
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// What this block does
// - Break is start, 13xN zeros, stop.
// - Break bit set sends breaks back to back.
// - Clearing break finishes character, then stops.
// - Sending a break raises no transmit interrupt.
// - Eight or nine bit words; ninth readable.
// - Sampling at 16x, shifting once per bit.
// - Each bit is a three-sample majority.
// - Word enters FIFO after stop, if room.
// - Data assembled least significant bit first.
// - Two-entry FIFO plus one word shifting.
// - Overrun sets flag, keeps FIFO, requests interrupt.
// - Receiver enable starts start-bit hunting.
// - Data flag while FIFO holds; interrupt requested.
// - Flags clear by status then data read.
// - Break completes as framing error with zeros.
// - After break wait for high line.
// - Idle flag low from start to stop.
// - Noise flag rises with data, no interrupt.
// - Zero in stop bits sets framing flag.
// - Parity mismatch sets parity flag with word.
// - Framing and parity flags cleared by reset.
module uartrb_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wrStb,
	input wire logic rdStb,
	output logic [7:0] rdata,
	input wire logic rxd,
	output logic txd,
	output logic rxIrq
);
	// ****************************************
	// Registers and state.
	// ****************************************
	typedef enum logic [2:0] {
		RX_HUNT = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_STOP = 3'h3,
		RX_STOP2 = 3'h4,
		RX_BRKWAIT = 3'h5
	} uartrb_rx_e;
	typedef enum logic [1:0] {
		TX_IDLE = 2'h0,
		TX_START = 2'h1,
		TX_ZERO = 2'h2,
		TX_STOP = 2'h3
	} uartrb_tx_e;
	uartrb_pkg::uartrb_cfg_s cfg_ff; // Software control bits.
	logic [7:0] baudDiv_ff; // Oversample divider reload.
	logic [7:0] divCnt_ff; // Oversample divider count.
	logic ovsTick; // One pulse per sixteenth of a bit.
	logic [1:0] rxSync_ff; // Receive pin synchroniser.
	logic rxPrev_ff; // Previous synchronised level.
	uartrb_rx_e rxState_ff; // Receiver state.
	logic [3:0] rxPhase_ff; // Oversample phase in the bit.
	logic [3:0] rxBit_ff; // Data bit index.
	logic [2:0] smp_ff; // The first two of the three mid-bit samples.
	logic [8:0] shift_ff; // Receive shift register.
	logic noiseAcc_ff; // Noise seen in this frame.
	logic rxIdle_ff; // Receiver idle flag.
	uartrb_pkg::uartrb_entry_s fifoMem_ff [2]; // FIFO storage.
	logic rdPtr_ff; // FIFO head.
	logic wrPtr_ff; // FIFO tail.
	logic [1:0] fifoCnt_ff; // Words held.
	logic overrun_ff; // Sticky overrun flag.
	logic noise_ff; // Sticky noise flag.
	logic armed_ff; // Status read seen since last data read.
	logic rxIrq_ff; // Receive interrupt request pulse.
	logic [7:0] rdata_ff; // Read data.
	uartrb_tx_e txState_ff; // Break transmitter state.
	logic [3:0] txPhase_ff; // Transmit oversample phase.
	logic [3:0] zeroCnt_ff; // Zero bits in this group of 13.
	logic stopCnt_ff; // Stop bits sent.
	logic txd_ff; // Transmit pin.
	logic bitTick; // End of a transmit bit.
	logic smpTick; // Mid-bit decision moment.
	logic endTick; // End of a receive bit.
	logic bitVal; // Majority of the samples.
	logic bitNoisy; // Samples disagree.
	logic rxDone; // Frame complete.
	logic doneFerr; // Completed frame had a framing error.
	logic [8:0] word; // Received word right aligned.
	logic push; // Word enters the FIFO.
	logic pop; // Software takes the head word.
	logic dataRead; // Read of the data register.
	logic statRead; // Read of the status register.
	uartrb_pkg::uartrb_entry_s head; // Head entry.
	uartrb_tx_e nxtTxState; // Next transmit state.
	// ****************************************
	// Decoding and oversample timing.
	// ****************************************
	assign dataRead = rdStb && (addr == uartrb_pkg::ADDR_DATA);
	assign statRead = rdStb && (addr == uartrb_pkg::ADDR_STATUS);
	assign head = fifoMem_ff[rdPtr_ff];
	assign pop = dataRead && (fifoCnt_ff != 2'h0);
	assign ovsTick = (divCnt_ff == 8'h00);
	assign smpTick = ovsTick && (rxPhase_ff == uartrb_pkg::SMP_LAST);
	assign endTick = ovsTick && (rxPhase_ff == uartrb_pkg::OVS_LAST);
	assign bitTick = ovsTick && (txPhase_ff == uartrb_pkg::OVS_LAST);
	// Majority of the three samples, the third taken now.
	assign bitVal = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & rxSync_ff[1])
		| (smp_ff[1] & rxSync_ff[1]);
	assign bitNoisy = !((smp_ff[0] == smp_ff[1]) && (smp_ff[1] == rxSync_ff[1]));
	// An eight-bit word sits one place high after its last shift.
	assign word = cfg_ff.nineBit ? shift_ff : {1'b0, shift_ff[8:1]};
	// Frame ends at the first stop bit low, or at the last stop bit.
	assign rxDone = smpTick && (((rxState_ff == RX_STOP) && (!bitVal || !cfg_ff.twoStop))
		|| (rxState_ff == RX_STOP2));
	assign doneFerr = rxDone && !bitVal;
	assign push = rxDone && (fifoCnt_ff != uartrb_pkg::FIFO_DEPTH);
	// Divider gives one oversample pulse per baudDiv+1 clocks.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			divCnt_ff <= 8'h00;
		end else if (ovsTick) begin
			divCnt_ff <= baudDiv_ff;
		end else begin
			divCnt_ff <= divCnt_ff - 8'h01;
		end
	end
	// Two flip-flops bring the pin into the clock domain.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxSync_ff <= 2'h3;
			rxPrev_ff <= 1'b1;
		end else begin
			rxSync_ff <= {rxSync_ff[0], rxd};
			rxPrev_ff <= rxSync_ff[1];
		end
	end
	// ****************************************
	// Software registers.
	// ****************************************
	// Control writes; the ninth bit and flags are read only.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			cfg_ff <= '0;
			baudDiv_ff <= uartrb_pkg::BAUD_RST;
		end else if (wrStb) begin
			if (addr == uartrb_pkg::ADDR_CTRL1) begin
				cfg_ff.nineBit <= wdata[uartrb_pkg::C1_NINE];
				cfg_ff.parityEn <= wdata[uartrb_pkg::C1_PAREN];
				cfg_ff.parityOdd <= wdata[uartrb_pkg::C1_PARODD];
				cfg_ff.twoStop <= wdata[uartrb_pkg::C1_TWOSTOP];
				cfg_ff.sendBreak <= wdata[uartrb_pkg::C1_BREAK];
				cfg_ff.rxEnable <= wdata[uartrb_pkg::C1_RECEIVER_ENABLE];
			end
			if (addr == uartrb_pkg::ADDR_CTRL2) begin
				cfg_ff.rxIrqEn <= wdata[uartrb_pkg::C2_RIE];
			end
			if (addr == uartrb_pkg::ADDR_BAUD) begin
				baudDiv_ff <= wdata;
			end
		end
	end
	// Read data stand in the cycle after the strobe.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_ff <= 8'h00;
		end else if (rdStb) begin
			unique case (addr)
				uartrb_pkg::ADDR_STATUS: begin
					rdata_ff <= 8'h00;
					rdata_ff[uartrb_pkg::ST_RXDATA] <= (fifoCnt_ff != 2'h0);
					rdata_ff[uartrb_pkg::ST_OVERRUN] <= overrun_ff;
					rdata_ff[uartrb_pkg::ST_NOISE] <= noise_ff;
					rdata_ff[uartrb_pkg::ST_FRAMING] <= (fifoCnt_ff != 2'h0) && head.framing;
					rdata_ff[uartrb_pkg::ST_PARITY] <= (fifoCnt_ff != 2'h0) && head.parity;
					rdata_ff[uartrb_pkg::ST_RXIDLE] <= rxIdle_ff;
					rdata_ff[uartrb_pkg::ST_TXIDLE] <= (txState_ff == TX_IDLE);
				end
				uartrb_pkg::ADDR_DATA: begin
					rdata_ff <= head.data;
				end
				uartrb_pkg::ADDR_CTRL1: begin
					rdata_ff <= {1'b0, cfg_ff.rxEnable, head.ninth, cfg_ff.sendBreak,
						cfg_ff.twoStop, cfg_ff.parityOdd, cfg_ff.parityEn, cfg_ff.nineBit};
				end
				uartrb_pkg::ADDR_CTRL2: begin
					rdata_ff <= {7'h00, cfg_ff.rxIrqEn};
				end
				uartrb_pkg::ADDR_BAUD: begin
					rdata_ff <= baudDiv_ff;
				end
				default: begin
					rdata_ff <= 8'h00; // Unmapped addresses read zero.
				end
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end
	// ****************************************
	// Receiver.
	// ****************************************
	// Frame sequencer: hunt, start, data, stop, break wait.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxState_ff <= RX_HUNT;
			rxPhase_ff <= 4'h0;
			rxBit_ff <= 4'h0;
		end else if (!cfg_ff.rxEnable) begin
			rxState_ff <= RX_HUNT;
			rxPhase_ff <= 4'h0;
		end else begin
			if (ovsTick) begin
				rxPhase_ff <= rxPhase_ff + 4'h1;
			end
			unique case (rxState_ff)
				RX_HUNT: begin
					if (rxPrev_ff && !rxSync_ff[1]) begin
						rxState_ff <= RX_START;
						rxPhase_ff <= 4'h0;
					end
				end
				RX_START: begin
					if (smpTick && bitVal) begin
						rxState_ff <= RX_HUNT;
					end else if (endTick) begin
						rxState_ff <= RX_DATA;
						rxBit_ff <= 4'h0;
					end
				end
				RX_DATA: begin
					if (endTick) begin
						if (rxBit_ff == (cfg_ff.nineBit ? uartrb_pkg::BITS_NINE
							: uartrb_pkg::BITS_EIGHT)) begin
							rxState_ff <= RX_STOP;
						end else begin
							rxBit_ff <= rxBit_ff + 4'h1;
						end
					end
				end
				RX_STOP: begin
					if (rxDone) begin
						rxState_ff <= bitVal ? RX_HUNT : RX_BRKWAIT;
					end else if (endTick) begin
						rxState_ff <= RX_STOP2;
					end
				end
				RX_STOP2: begin
					if (rxDone) begin
						rxState_ff <= bitVal ? RX_HUNT : RX_BRKWAIT;
					end
				end
				RX_BRKWAIT: begin
					if (rxSync_ff[1]) begin
						rxState_ff <= RX_HUNT;
					end
				end
				default: begin
					rxState_ff <= RX_HUNT;
				end
			endcase
		end
	end
	// Samples, shifting once per bit, and noise gathering.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			smp_ff <= 3'h7;
			shift_ff <= 9'h000;
			noiseAcc_ff <= 1'b0;
		end else begin
			if (ovsTick && (rxPhase_ff == uartrb_pkg::SMP_FIRST)) begin
				smp_ff[0] <= rxSync_ff[1];
			end
			if (ovsTick && (rxPhase_ff == uartrb_pkg::SMP_MID)) begin
				smp_ff[1] <= rxSync_ff[1];
			end
			if (rxState_ff == RX_HUNT) begin
				noiseAcc_ff <= 1'b0;
			end else if (smpTick && bitNoisy) begin
				noiseAcc_ff <= 1'b1;
			end
			if (smpTick && (rxState_ff == RX_DATA)) begin
				shift_ff <= {bitVal, shift_ff[8:1]};
			end
		end
	end
	// Idle flag: low from start detection to stop reception.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxIdle_ff <= 1'b1;
		end else if (rxDone || !cfg_ff.rxEnable) begin
			rxIdle_ff <= 1'b1;
		end else if ((rxState_ff == RX_HUNT) && rxPrev_ff && !rxSync_ff[1]) begin
			rxIdle_ff <= 1'b0;
		end else if ((rxState_ff == RX_START) && smpTick && bitVal) begin
			// A start edge that is high again at mid-bit was a glitch, so the receiver is idle.
			rxIdle_ff <= 1'b1;
		end
	end
	// ****************************************
	// Receive FIFO and flags.
	// ****************************************
	// Two entries; a full FIFO keeps its words on overrun.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdPtr_ff <= 1'b0;
			wrPtr_ff <= 1'b0;
			fifoCnt_ff <= 2'h0;
			fifoMem_ff[0] <= '0;
			fifoMem_ff[1] <= '0;
		end else begin
			if (push) begin
				fifoMem_ff[wrPtr_ff].ninth <= word[8];
				fifoMem_ff[wrPtr_ff].data <= doneFerr ? 8'h00 : word[7:0];
				fifoMem_ff[wrPtr_ff].framing <= doneFerr;
				fifoMem_ff[wrPtr_ff].parity <= cfg_ff.parityEn
					&& ((^word[8:0]) != cfg_ff.parityOdd);
				wrPtr_ff <= !wrPtr_ff;
			end
			if (pop) begin
				rdPtr_ff <= !rdPtr_ff;
			end
			if (push && !pop) begin
				fifoCnt_ff <= fifoCnt_ff + 2'h1;
			end else if (pop && !push) begin
				fifoCnt_ff <= fifoCnt_ff - 2'h1;
			end
		end
	end
	// Status read arms the clear; the next data read fires it.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			armed_ff <= 1'b0;
		end else if (statRead) begin
			armed_ff <= 1'b1;
		end else if (dataRead) begin
			armed_ff <= 1'b0;
		end
	end
	// Sticky overrun and noise; a new event wins over the clear.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			overrun_ff <= 1'b0;
			noise_ff <= 1'b0;
		end else begin
			if (rxDone && !push) begin
				overrun_ff <= 1'b1;
			end else if (dataRead && armed_ff) begin
				overrun_ff <= 1'b0;
			end
			// Noise on the closing stop bit counts too; it is seen in the same cycle as the push.
			if (push && (noiseAcc_ff || bitNoisy)) begin
				noise_ff <= 1'b1;
			end else if (dataRead && armed_ff) begin
				noise_ff <= 1'b0;
			end
		end
	end
	// Interrupt request on each FIFO load and on overrun only.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rxIrq_ff <= 1'b0;
		end else begin
			rxIrq_ff <= rxDone && cfg_ff.rxIrqEn;
		end
	end
	// ****************************************
	// Break transmitter.
	// ****************************************
	// Next state of the break sequencer.
	always_comb begin
		nxtTxState = txState_ff;
		unique case (txState_ff)
			TX_IDLE: begin
				// Starting on an oversample tick makes the start bit a full sixteen ticks long.
				if (cfg_ff.sendBreak && ovsTick) begin
					nxtTxState = TX_START;
				end
			end
			TX_START: begin
				if (bitTick) begin
					nxtTxState = TX_ZERO;
				end
			end
			TX_ZERO: begin
				if (bitTick && (zeroCnt_ff == uartrb_pkg::BRK_LAST) && !cfg_ff.sendBreak) begin
					nxtTxState = TX_STOP;
				end
			end
			TX_STOP: begin
				if (bitTick && (stopCnt_ff == cfg_ff.twoStop)) begin
					nxtTxState = TX_IDLE;
				end
			end
		endcase
	end
	// Break sequencer; it raises no transmit interrupt.
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			txState_ff <= TX_IDLE;
			txPhase_ff <= 4'h0;
			zeroCnt_ff <= 4'h0;
			stopCnt_ff <= 1'b0;
			txd_ff <= 1'b1;
		end else begin
			txState_ff <= nxtTxState;
			txd_ff <= (nxtTxState == TX_IDLE) || (nxtTxState == TX_STOP);
			if (txState_ff == TX_IDLE) begin
				txPhase_ff <= 4'h0;
			end else if (ovsTick) begin
				txPhase_ff <= txPhase_ff + 4'h1;
			end
			if (bitTick && (txState_ff == TX_ZERO)) begin
				zeroCnt_ff <= (zeroCnt_ff == uartrb_pkg::BRK_LAST) ? 4'h0
					: zeroCnt_ff + 4'h1;
			end else if (txState_ff != TX_ZERO) begin
				zeroCnt_ff <= 4'h0;
			end
			if (bitTick && (txState_ff == TX_STOP)) begin
				stopCnt_ff <= 1'b1;
			end else if (txState_ff != TX_STOP) begin
				stopCnt_ff <= 1'b0;
			end
		end
	end
	assign rdata = rdata_ff;
	assign txd = txd_ff;
	assign rxIrq = rxIrq_ff;
	// ****************************************
	// Assertions.
	// ****************************************
	property p_brk_low;
		@(posedge mclk) disable iff (!rst_n)
		(txState_ff == TX_START) || (txState_ff == TX_ZERO) |-> !txd_ff;
	endproperty
	a_brk_low: assert property (p_brk_low) else $error("break not low");
	property p_brk_repeat;
		@(posedge mclk) disable iff (!rst_n)
		(txState_ff == TX_ZERO) && bitTick && (zeroCnt_ff == uartrb_pkg::BRK_LAST)
		&& cfg_ff.sendBreak
		|=> (txState_ff == TX_ZERO) && (zeroCnt_ff == 4'h0);
	endproperty
	a_brk_repeat: assert property (p_brk_repeat) else $error("break not repeated");
	property p_brk_stop;
		@(posedge mclk) disable iff (!rst_n)
		(txState_ff == TX_ZERO) && bitTick && (zeroCnt_ff == uartrb_pkg::BRK_LAST)
		&& !cfg_ff.sendBreak
		|=> (txState_ff == TX_STOP) && txd_ff;
	endproperty
	a_brk_stop: assert property (p_brk_stop) else $error("stop not sent");
	property p_overrun;
		@(posedge mclk) disable iff (!rst_n)
		rxDone && (fifoCnt_ff == 2'h2) && !pop |=> overrun_ff && (fifoCnt_ff == 2'h2);
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun lost");
	property p_irq;
		@(posedge mclk) disable iff (!rst_n)
		rxDone && cfg_ff.rxIrqEn |=> rxIrq_ff;
	endproperty
	a_irq: assert property (p_irq) else $error("no receive request");
	property p_hold;
		@(posedge mclk) disable iff (!rst_n)
		overrun_ff && !(dataRead && armed_ff) |=> overrun_ff;
	endproperty
	a_hold: assert property (p_hold) else $error("overrun cleared early");
	property p_idle;
		@(posedge mclk) disable iff (!rst_n)
		(rxState_ff == RX_HUNT) && cfg_ff.rxEnable && rxPrev_ff && !rxSync_ff[1]
		|=> !rxIdle_ff && (rxState_ff == RX_START);
	endproperty
	a_idle: assert property (p_idle) else $error("idle not dropped");
	property p_brkwait;
		@(posedge mclk) disable iff (!rst_n)
		doneFerr && cfg_ff.rxEnable |=> (rxState_ff == RX_BRKWAIT) && rxIdle_ff;
	endproperty
	a_brkwait: assert property (p_brkwait) else $error("break not waited");
endmodule : uartrb_top

// ---- uartrb_peer.sv ----
// Remote serial transmitter model that drives the receive pin of the block.
`timescale 1ns/1ps
// ****************************************
// Remote transmitter.
// ****************************************
module uartrb_peer #(
	parameter int BIT_CLKS = 64
) (
	input wire logic mclk,
	output logic rxd
);
	// The line idles high between frames.
	initial rxd = 1'b1;
	// Holds one line level for a number of bit times.
	task automatic put_level(input logic lvl, input int nbits);
		rxd <= lvl;
		repeat (nbits * BIT_CLKS) @(posedge mclk);
	endtask : put_level
	// Holds one bit with a one-tick glitch just past mid-bit.
	// The glitch covers four clocks, so it flips exactly one of the three samples.
	task automatic put_glitch(input logic lvl);
		rxd <= lvl;
		repeat (BIT_CLKS / 2 + 1) @(posedge mclk);
		rxd <= !lvl;
		repeat (BIT_CLKS / 16) @(posedge mclk);
		rxd <= lvl;
		repeat (BIT_CLKS / 2 - 1 - BIT_CLKS / 16) @(posedge mclk);
	endtask : put_glitch
	// Sends a frame whose data bit with index noisy carries a glitch.
	task automatic send_noisy(input logic [8:0] w, input int nb, input int noisy);
		put_level(1'b0, 1);
		for (int i = 0; i < nb; i++) begin
			if (i == noisy) begin
				put_glitch(w[i]);
			end else begin
				put_level(w[i], 1);
			end
		end
		put_level(1'b1, 1);
	endtask : send_noisy
	// Sends a start bit, the word least significant bit first, then one stop bit.
	task automatic send(input logic [8:0] w, input int nb);
		send_noisy(w, nb, -1);
	endtask : send
endmodule : uartrb_peer

// ---- tb_top.sv ----
// Self-checking testbench of the serial receiver and break generator.
`timescale 1ns/1ps
module tb_top;
	// ****************************************
	// Signals and instances.
	// ****************************************
	localparam int BIT = 64; // Clocks per bit with baud divider 3.
	logic mclk, rst_n, wrStb, rdStb, txd, rxIrq, rxd;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, got;
	int n_errors = 0, total_checks = 0, irqCount = 0, lowCount = 0;
	uartrb_top uartrb_top_inst (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wrStb(wrStb), .rdStb(rdStb), .rdata(rdata), .rxd(rxd), .txd(txd), .rxIrq(rxIrq));
	uartrb_peer #(.BIT_CLKS(BIT)) uartrb_peer_inst (.mclk(mclk), .rxd(rxd));
	// Clock of 20 ns.
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Counts interrupt pulses and clocks with the transmit pin low.
	always @(posedge mclk) begin
		if (rxIrq === 1'b1) irqCount++;
		if (txd === 1'b0) lowCount++;
	end
	// ****************************************
	// Shared tasks.
	// ****************************************
	// Compares a seen value with the expected one.
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// One write cycle.
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		wrStb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wrStb <= 1'b0;
	endtask : wr
	// One read cycle; the data stand in the following cycle.
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge mclk);
		rdStb <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rdStb <= 1'b0;
		#1 got = rdata;
		chk(got, e);
	endtask : rdc
	// Status then data read, as software clears the flags.
	task automatic sd(input logic [7:0] s, input logic [7:0] d);
		rdc(uartrb_pkg::ADDR_STATUS, s);
		rdc(uartrb_pkg::ADDR_DATA, d);
	endtask : sd
	// Sends one frame and lets the synchroniser settle.
	task automatic frame(input logic [8:0] w, input int nb);
		uartrb_peer_inst.send(w, nb);
		repeat (4) @(posedge mclk);
	endtask : frame
	// Fast baud, receive interrupt on, receiver on.
	task automatic cfg;
		wr(uartrb_pkg::ADDR_BAUD, 8'h03);
		wr(uartrb_pkg::ADDR_CTRL2, 8'h01);
		wr(uartrb_pkg::ADDR_CTRL1, 8'h40);
	endtask : cfg
	// Prints the counts and the verdict, then ends the run.
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	// ****************************************
	// Scenarios.
	// ****************************************
	// Reset values and an unmapped address.
	task automatic t_reset;
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		rdc(uartrb_pkg::ADDR_BAUD, 8'h19);
		rdc(3'h7, 8'h00);
		cfg();
		$display("reset test done");
	endtask : t_reset
	// Two words, least significant bit first, one interrupt each.
	task automatic t_two;
		frame(9'h0A5, 8);
		frame(9'h03C, 8);
		chk(irqCount, 2);
		sd(8'h61, 8'hA5);
		sd(8'h61, 8'h3C);
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		$display("two word test done");
	endtask : t_two
	// Third word overruns a full FIFO.
	task automatic t_overrun;
		frame(9'h011, 8);
		frame(9'h022, 8);
		frame(9'h033, 8);
		chk(irqCount, 5);
		sd(8'h63, 8'h11);
		sd(8'h61, 8'h22);
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		$display("overrun test done");
	endtask : t_overrun
	// Long break, recovery, then a second break whose framing entry reset clears.
	task automatic t_break_rx;
		uartrb_peer_inst.put_level(1'b0, 20);
		uartrb_peer_inst.put_level(1'b1, 2);
		frame(9'h05A, 8);
		sd(8'h69, 8'h00);
		sd(8'h61, 8'h5A);
		uartrb_peer_inst.put_level(1'b0, 20);
		uartrb_peer_inst.put_level(1'b1, 2);
		rst_n <= 1'b0;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		cfg();
		$display("receive break test done");
	endtask : t_break_rx
	// Even parity, one bad word and one good word.
	task automatic t_parity;
		wr(uartrb_pkg::ADDR_CTRL1, 8'h42);
		frame(9'h001, 8);
		frame(9'h003, 8);
		sd(8'h71, 8'h01);
		sd(8'h61, 8'h03);
		wr(uartrb_pkg::ADDR_CTRL1, 8'h40);
		$display("parity test done");
	endtask : t_parity
	// Nine-bit word with the top bit set.
	task automatic t_nine;
		wr(uartrb_pkg::ADDR_CTRL1, 8'h41);
		frame(9'h1A5, 9);
		rdc(uartrb_pkg::ADDR_CTRL1, 8'h61);
		sd(8'h61, 8'hA5);
		wr(uartrb_pkg::ADDR_CTRL1, 8'h40);
		$display("nine bit test done");
	endtask : t_nine
	// Noisy data bit with two stop bits: noise flag beside the word, no extra request.
	task automatic t_noise;
		int irq0;
		irq0 = irqCount;
		wr(uartrb_pkg::ADDR_CTRL1, 8'h48);
		uartrb_peer_inst.send_noisy(9'h055, 8, 2);
		repeat (BIT + 4) @(posedge mclk);
		chk(irqCount, irq0 + 1);
		sd(8'h65, 8'h55);
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		wr(uartrb_pkg::ADDR_CTRL1, 8'h40);
		$display("noise test done");
	endtask : t_noise
	// Break held over two groups, then cleared mid-group.
	task automatic t_break_tx;
		int irq0;
		irq0 = irqCount;
		lowCount = 0;
		wr(uartrb_pkg::ADDR_CTRL1, 8'h50);
		repeat (20 * BIT) @(posedge mclk);
		wr(uartrb_pkg::ADDR_CTRL1, 8'h40);
		repeat (10 * BIT) @(posedge mclk);
		chk(lowCount, 27 * BIT);
		chk(txd, 1'b1);
		chk(irqCount, irq0);
		rdc(uartrb_pkg::ADDR_STATUS, 8'h60);
		$display("transmit break test done");
	endtask : t_break_tx
	// ****************************************
	// Main sequence and watchdog.
	// ****************************************
	initial begin
		rst_n = 1'b0;
		wrStb = 1'b0;
		rdStb = 1'b0;
		addr = 3'h0;
		wdata = 8'h00;
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_two();
		t_overrun();
		t_break_rx();
		t_parity();
		t_nine();
		t_noise();
		t_break_tx();
		report_and_stop();
	end
	// Cuts a hang short well after the expected run length.
	initial begin
		repeat (40000) @(posedge mclk);
		n_errors++;
		$display("BAD t=%0t watchdog expired", $time);
		report_and_stop();
	end
endmodule : tb_top
